/* logic/dur_pkg.sv */
/*
 Shared constants and carrier types for one serial channel's register bank.
 Assumes a single 25 MHz system clock and an 8-bit parallel host bus.
*/
`default_nettype none
package dur_pkg;
  localparam int             PIN_W       = 20;
  // {rst, cs_n, ior_n, iow_n, addr[2:0], d[7:0], rx, modem_n[3:0]} at rest
  localparam logic [19:0]    PIN_IDLE    = 20'h7001f;

  // Offsets in the standard bank
  localparam logic [2:0]     A_HOLD      = 3'h0;
  localparam logic [2:0]     A_IER       = 3'h1;
  localparam logic [2:0]     A_ISR       = 3'h2;
  localparam logic [2:0]     A_LCR       = 3'h3;
  localparam logic [2:0]     A_MCR       = 3'h4;
  localparam logic [2:0]     A_LSR       = 3'h5;
  localparam logic [2:0]     A_MSR       = 3'h6;
  localparam logic [2:0]     A_SPR       = 3'h7;
  // Divisor bank (line control bit 7 set)
  localparam logic [2:0]     A_DIV_LO    = 3'h0;
  localparam logic [2:0]     A_DIV_HI    = 3'h1;
  // Enhanced bank (line control equal to key)
  localparam logic [2:0]     A_QCOUNT    = 3'h0;
  localparam logic [2:0]     A_QLEVEL    = 3'h1;
  localparam logic [2:0]     A_EFR       = 3'h2;
  localparam logic [2:0]     A_RES1      = 3'h4;
  localparam logic [2:0]     A_RES2      = 3'h5;
  localparam logic [2:0]     A_PAU1      = 3'h6;
  localparam logic [2:0]     A_PAU2      = 3'h7;

  localparam int             LCR_DLAB    = 7;
  localparam logic [7:0]     LCR_ENH_KEY = 8'hbf;
  localparam int             EFR_ENH     = 4;
  localparam int             MS_RI       = 2;
  localparam logic [7:0]     IER_ENH_MSK = 8'hf0;
  localparam logic [7:0]     FCR_ENH_MSK = 8'h30;
  localparam logic [7:0]     MCR_ENH_MSK = 8'he0;

  localparam logic [15:0]    RST_DIV     = 16'h0001;
  localparam logic [7:0]     RST_ISR     = 8'h01;
  localparam logic [7:0]     RST_LSR     = 8'h60;
  localparam int             BAUD_OVERSAMPLE = 16;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } dur_bus_t;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] queue_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratchpad;
    logic [7:0] enhanced_mode_select;
    logic [7:0] enhanced_feature;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
  } dur_cfg_t;

  localparam dur_cfg_t RST_CFG = '{interrupt_enable: 8'h00, queue_control: 8'h00, line_control: 8'h00, modem_control: 8'h00,
                                   scratchpad: 8'hff, enhanced_mode_select: 8'h80, enhanced_feature: 8'h00,
                                   resume_char_one: 8'h00, resume_char_two: 8'h00,
                                   pause_char_one: 8'h00, pause_char_two: 8'h00};

  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] int_source;
    logic [7:0] line_status;
    logic [7:0] rx_level;
    logic [7:0] tx_level;
  } dur_stat_t;

  typedef struct packed {
    logic       thr_wr;
    logic       fcr_wr;
    logic       rhr_rd;
    logic       isr_rd;
    logic       lsr_rd;
    logic       msr_rd;
    logic [7:0] data;
  } dur_evt_t;
endpackage
`default_nettype wire

/* logic/dur_baud.sv */
/*
 Baud tick generator: divides the system clock by the divisor, then by the
 oversampling ratio. Assumes the divisor is held in a register upstream and
 that div_load pulses the cycle after the divisor changed.
*/
`timescale 1ns/1ps
`default_nettype none
module dur_baud #(
  parameter int DIV_W      = 16,
  parameter int OVERSAMPLE = dur_pkg::BAUD_OVERSAMPLE
) (
  input  wire logic             clk,      // System clock
  input  wire logic             resetn,   // Synchronous reset, active low
  input  wire logic             ce,       // Clock enable
  input  wire logic [DIV_W-1:0] divisor,  // Divisor, zero acts as full range
  input  wire logic             div_load, // Restart count with new divisor
  output logic                  os_tick,  // Oversample tick
  output logic                  bit_tick  // One per bit time
);
  localparam int               OS_W   = (OVERSAMPLE > 1) ? $clog2(OVERSAMPLE) : 1;
  localparam logic [OS_W-1:0]  OS_MAX = OS_W'(OVERSAMPLE - 1);

  if (OVERSAMPLE < 2 || DIV_W < 1) begin : g_bad
    $error("dur_baud: unsupported parameters");
  end

  logic [DIV_W-1:0] div_cnt_r;
  logic [OS_W-1:0]  os_cnt_r;

  assign os_tick  = ce && div_cnt_r == '0;
  assign bit_tick = os_tick && os_cnt_r == OS_MAX;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_cnt_r <= '0;
      os_cnt_r  <= '0;
    end else if (ce) begin
      div_cnt_r <= (div_load || os_tick) ? divisor - DIV_W'(1) : div_cnt_r - DIV_W'(1);
      if (os_tick) begin
        os_cnt_r <= (os_cnt_r == OS_MAX) ? '0 : os_cnt_r + OS_W'(1);
      end
    end
  end

  // Gap in enabled cycles since the last tick or reload
  logic [DIV_W:0] gap_r;
  logic           armed_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_r   <= '0;
      armed_r <= 1'b0;
    end else if (ce) begin
      gap_r   <= (os_tick || div_load) ? (DIV_W+1)'(1) : gap_r + (DIV_W+1)'(1);
      armed_r <= armed_r || os_tick || div_load;
    end
  end

  property p_tick_rate;
    @(posedge clk) disable iff (!resetn)
      os_tick && armed_r && $stable(divisor) && divisor != '0 && !$past(div_load)
        |-> gap_r == {1'b0, divisor};
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("oversample tick spacing differs from divisor");

  sequence s_bit_end;
    os_tick && os_cnt_r == OS_MAX;
  endsequence
  property p_bit_rate;
    @(posedge clk) disable iff (!resetn)
      s_bit_end |=> os_cnt_r == '0;
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("bit tick not at oversample wrap");
endmodule
`default_nettype wire

/* logic/dur_regs.sv */
/*
 Register bank of one serial channel: host bus slave, reset handling,
 flow control characters, modem status and sleep isolation.
 Assumes the transmit/receive datapath sits outside, takes cfg and evt,
 and returns its state on stat; all pins arrive asynchronous to clk.
*/
// Operation
// - Four read/write flow control character registers
// - Baud divisor initialises to 0x0001
// - Only power-up reset loads the divisor
// - Reset clears deltas; status shows inverted inputs
// - Sleep isolates bus and receive inputs
// - Bit rate is clock/16/divisor
`timescale 1ns/1ps
`default_nettype none
module dur_regs (
  input  wire logic               clk,          // 25 MHz system clock
  input  wire logic               resetn,       // Power-up reset, active low
  input  wire logic               ce,           // Clock enable
  input  wire logic               rst_pin,      // External reset pin, active high
  input  wire logic               cs_n,         // Chip select pin
  input  wire logic               ior_n,        // Read strobe pin
  input  wire logic               iow_n,        // Write strobe pin
  input  wire logic [2:0]         addr,         // Register address pins
  input  wire logic [7:0]         d_in,         // Data bus in
  output logic [7:0]              d_out,        // Data bus out
  output logic                    d_oe,         // Data bus drive enable
  input  wire logic               rx_pin,       // Serial receive pin
  input  wire logic [3:0]         modem_n,      // {cd, ri, dsr, cts} pins, active low
  input  wire logic               sleep_en,     // Sleep request from channel logic
  input  wire dur_pkg::dur_stat_t stat,         // Datapath state
  output dur_pkg::dur_cfg_t       cfg,          // Register contents
  output logic [15:0]             divisor,      // Baud divisor
  output dur_pkg::dur_evt_t       evt,          // Access pulses and write data
  output logic                    chan_rst,     // Channel reset to datapath
  output logic                    rx_line,      // Receive line after isolation
  output logic [7:0]              modem_status, // Live modem status
  output logic                    os_tick,      // Oversample tick
  output logic                    bit_tick      // Bit-rate tick
);
  localparam int PW = dur_pkg::PIN_W;

  // Two-stage synchronisers for every pin
  logic [PW-1:0] sync1_r;
  logic [PW-1:0] sync2_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Modem bits keep sampling so no false delta follows reset
      sync1_r <= {dur_pkg::PIN_IDLE[PW-1:4], modem_n};
      sync2_r <= {dur_pkg::PIN_IDLE[PW-1:4], sync1_r[3:0]};
    end else if (ce) begin
      sync1_r <= {rst_pin, cs_n, ior_n, iow_n, addr, d_in, rx_pin, modem_n};
      sync2_r <= sync1_r;
    end
  end

  wire logic        rst_pin_s = sync2_r[19];
  wire logic        rx_s      = sync2_r[4];
  wire logic [3:0]  modem_s   = sync2_r[3:0];
  // Bus pins read as idle while asleep; modem pins stay live
  wire logic [13:0] bus_e     = sleep_en ? dur_pkg::PIN_IDLE[18:5] : sync2_r[18:5];
  wire logic        cs_e      = bus_e[13];
  wire logic        ior_e     = bus_e[12];
  wire logic        iow_e     = bus_e[11];
  wire logic [2:0]  addr_e    = bus_e[10:8];
  wire logic [7:0]  d_e       = bus_e[7:0];

  assign chan_rst = !resetn || rst_pin_s;
  assign rx_line  = sleep_en || rx_s;

  // Bus access sequencer
  dur_pkg::dur_bus_t bus_st_r;
  dur_pkg::dur_bus_t bus_st_nxt;
  logic              rd_go;
  logic              wr_go;
  always_comb begin
    bus_st_nxt = bus_st_r;
    rd_go      = 1'b0;
    wr_go      = 1'b0;
    unique case (bus_st_r)
      dur_pkg::BUS_IDLE: begin
        if (!cs_e && !ior_e) begin
          bus_st_nxt = dur_pkg::BUS_READ;
          rd_go      = 1'b1;
        end else if (!cs_e && !iow_e) begin
          bus_st_nxt = dur_pkg::BUS_WRITE;
        end
      end
      dur_pkg::BUS_READ: begin
        if (cs_e || ior_e) begin
          bus_st_nxt = dur_pkg::BUS_IDLE;
        end
      end
      dur_pkg::BUS_WRITE: begin
        if (cs_e || iow_e) begin
          bus_st_nxt = dur_pkg::BUS_IDLE;
          wr_go      = 1'b1;
        end
      end
      default: begin
        bus_st_nxt = dur_pkg::BUS_IDLE;
      end
    endcase
  end

  logic [2:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] d_out_r;
  logic [7:0] rd_val;
  wire  logic rd_start  = rd_go && ce && !chan_rst;
  wire  logic wr_commit = wr_go && ce && !chan_rst;

  dur_pkg::dur_cfg_t cfg_r;
  logic [15:0]       div_r;
  wire logic dlab  = cfg_r.line_control[dur_pkg::LCR_DLAB];
  wire logic enh   = cfg_r.line_control == dur_pkg::LCR_ENH_KEY;
  wire logic w_std = wr_commit && !enh;
  wire logic w_enh = wr_commit && enh;

  // Write decode
  wire logic wr_thr  = w_std && !dlab && wr_addr_r == dur_pkg::A_HOLD;
  wire logic wr_ier  = w_std && !dlab && wr_addr_r == dur_pkg::A_IER;
  wire logic wr_dlo  = w_std && dlab && wr_addr_r == dur_pkg::A_DIV_LO;
  wire logic wr_dhi  = w_std && dlab && wr_addr_r == dur_pkg::A_DIV_HI;
  wire logic wr_fcr  = w_std && wr_addr_r == dur_pkg::A_ISR;
  wire logic wr_lcr  = wr_commit && wr_addr_r == dur_pkg::A_LCR;
  wire logic wr_mcr  = w_std && wr_addr_r == dur_pkg::A_MCR;
  wire logic wr_spr  = w_std && wr_addr_r == dur_pkg::A_SPR;
  wire logic wr_enhanced_mode_select = w_enh && wr_addr_r == dur_pkg::A_QCOUNT;
  wire logic wr_efr  = w_enh && wr_addr_r == dur_pkg::A_EFR;
  wire logic wr_res1 = w_enh && wr_addr_r == dur_pkg::A_RES1;
  wire logic wr_res2 = w_enh && wr_addr_r == dur_pkg::A_RES2;
  wire logic wr_pau1 = w_enh && wr_addr_r == dur_pkg::A_PAU1;
  wire logic wr_pau2 = w_enh && wr_addr_r == dur_pkg::A_PAU2;

  // Read side effects
  wire logic rd_rhr = rd_start && !dlab && addr_e == dur_pkg::A_HOLD;
  wire logic rd_isr = rd_start && !enh && addr_e == dur_pkg::A_ISR;
  wire logic rd_lsr = rd_start && !enh && addr_e == dur_pkg::A_LSR;
  wire logic rd_msr = rd_start && !enh && addr_e == dur_pkg::A_MSR;

  // Enhanced bits change only while the unlock bit is set
  function automatic logic [7:0] guard(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask,
                                       input logic       unlock);
    return unlock ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction

  always_ff @(posedge clk) begin
    if (chan_rst) begin
      bus_st_r  <= dur_pkg::BUS_IDLE;
      wr_addr_r <= 3'h0;
      wr_data_r <= 8'h00;
      d_out_r   <= 8'h00;
    end else if (ce) begin
      bus_st_r <= bus_st_nxt;
      if (!cs_e && !iow_e) begin
        wr_addr_r <= addr_e;
        wr_data_r <= d_e;
      end
      if (rd_start) begin
        d_out_r <= rd_val;
      end
    end
  end

  assign d_out = d_out_r;
  assign d_oe  = bus_st_r == dur_pkg::BUS_READ;

  // Divisor: power-up reset only, untouched by the reset pin
  logic div_load_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_r      <= dur_pkg::RST_DIV;
      div_load_r <= 1'b0;
    end else if (ce) begin
      if (wr_dlo) begin
        div_r[7:0] <= wr_data_r;
      end
      if (wr_dhi) begin
        div_r[15:8] <= wr_data_r;
      end
      div_load_r <= wr_dlo || wr_dhi;
    end
  end
  assign divisor = div_r;

  always_ff @(posedge clk) begin
    if (chan_rst) begin
      cfg_r <= dur_pkg::RST_CFG;
    end else if (ce) begin
      if (wr_ier)  cfg_r.interrupt_enable  <= guard(cfg_r.interrupt_enable, wr_data_r, dur_pkg::IER_ENH_MSK, cfg_r.enhanced_feature[dur_pkg::EFR_ENH]);
      if (wr_fcr)  cfg_r.queue_control  <= guard(cfg_r.queue_control, wr_data_r, dur_pkg::FCR_ENH_MSK, cfg_r.enhanced_feature[dur_pkg::EFR_ENH]);
      if (wr_mcr)  cfg_r.modem_control  <= guard(cfg_r.modem_control, wr_data_r, dur_pkg::MCR_ENH_MSK, cfg_r.enhanced_feature[dur_pkg::EFR_ENH]);
      if (wr_lcr)  cfg_r.line_control  <= wr_data_r;
      if (wr_spr)  cfg_r.scratchpad  <= wr_data_r;
      if (wr_enhanced_mode_select) cfg_r.enhanced_mode_select <= wr_data_r;
      if (wr_efr)  cfg_r.enhanced_feature  <= wr_data_r;
      if (wr_res1) cfg_r.resume_char_one <= wr_data_r;
      if (wr_res2) cfg_r.resume_char_two <= wr_data_r;
      if (wr_pau1) cfg_r.pause_char_one  <= wr_data_r;
      if (wr_pau2) cfg_r.pause_char_two  <= wr_data_r;
    end
  end
  assign cfg = cfg_r;

  // Modem status: deltas sticky until read, a new change wins over the read
  logic [3:0] mprev_r;
  logic [3:0] delta_r;
  wire  logic [3:0] mchg = mprev_r ^ modem_s;
  wire  logic [3:0] mset = {mchg[3], ~mprev_r[dur_pkg::MS_RI] & modem_s[dur_pkg::MS_RI], mchg[1:0]};
  always_ff @(posedge clk) begin
    if (chan_rst) begin
      delta_r <= 4'h0;
      mprev_r <= modem_s;
    end else if (ce) begin
      delta_r <= (delta_r & ~{4{rd_msr}}) | mset;
      mprev_r <= modem_s;
    end
  end
  assign modem_status = {~modem_s, delta_r};

  // Read data selection
  logic [7:0] bank_n [8];
  logic [7:0] bank_e [8];
  assign bank_n[0] = stat.rx_data;
  assign bank_n[1] = cfg_r.interrupt_enable;
  assign bank_n[2] = stat.int_source;
  assign bank_n[3] = cfg_r.line_control;
  assign bank_n[4] = cfg_r.modem_control;
  assign bank_n[5] = stat.line_status;
  assign bank_n[6] = modem_status;
  assign bank_n[7] = cfg_r.scratchpad;
  assign bank_e[0] = stat.rx_level;
  assign bank_e[1] = stat.tx_level;
  assign bank_e[2] = cfg_r.enhanced_feature;
  assign bank_e[3] = cfg_r.line_control;
  assign bank_e[4] = cfg_r.resume_char_one;
  assign bank_e[5] = cfg_r.resume_char_two;
  assign bank_e[6] = cfg_r.pause_char_one;
  assign bank_e[7] = cfg_r.pause_char_two;

  assign rd_val = enh                                    ? bank_e[addr_e] :
                  (dlab && addr_e == dur_pkg::A_DIV_LO) ? div_r[7:0]     :
                  (dlab && addr_e == dur_pkg::A_DIV_HI) ? div_r[15:8]    :
                                                          bank_n[addr_e];

  dur_pkg::dur_evt_t evt_r;
  always_ff @(posedge clk) begin
    if (chan_rst) begin
      evt_r <= '0;
    end else if (ce) begin
      evt_r <= {wr_thr, wr_fcr, rd_rhr, rd_isr, rd_lsr, rd_msr, wr_data_r};
    end
  end
  assign evt = evt_r;

  dur_baud #(
    .DIV_W      (16),
    .OVERSAMPLE (dur_pkg::BAUD_OVERSAMPLE)
  ) u_baud (
    .clk      (clk),
    .resetn   (!chan_rst),
    .ce       (ce),
    .divisor  (div_r),
    .div_load (div_load_r),
    .os_tick  (os_tick),
    .bit_tick (bit_tick)
  );

  // Checks
  property p_flow_write;
    @(posedge clk) disable iff (chan_rst)
      wr_res1 |=> cfg_r.resume_char_one == $past(wr_data_r);
  endproperty
  a_flow_write: assert property (p_flow_write) else $error("resume char one not stored");

  property p_flow_read;
    @(posedge clk) disable iff (chan_rst)
      rd_start && enh && addr_e == dur_pkg::A_PAU2 |=> d_out == $past(cfg_r.pause_char_two);
  endproperty
  a_flow_read: assert property (p_flow_read) else $error("pause char two readback wrong");

  property p_div_por;
    @(posedge clk) disable iff (!resetn)
      !$past(resetn) |-> div_r == dur_pkg::RST_DIV;
  endproperty
  a_div_por: assert property (p_div_por) else $error("divisor not 1 after power-up reset");

  property p_div_pin;
    @(posedge clk) disable iff (!resetn)
      rst_pin_s |=> $stable(div_r) && cfg_r.line_control == dur_pkg::RST_CFG.line_control && cfg_r.scratchpad == dur_pkg::RST_CFG.scratchpad;
  endproperty
  a_div_pin: assert property (p_div_pin) else $error("pin reset altered divisor or missed others");

  property p_msr_clear;
    @(posedge clk) disable iff (!resetn)
      rst_pin_s |=> modem_status[3:0] == 4'h0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("modem deltas not cleared by reset");

  sequence s_live3;
    (ce && resetn)[*3];
  endsequence
  property p_msr_level;
    @(posedge clk) disable iff (!resetn)
      s_live3 |-> modem_status[7:4] == ~$past(modem_n, 2);
  endproperty
  a_msr_level: assert property (p_msr_level) else $error("modem status not inverted pin levels");

  sequence s_asleep3;
    sleep_en[*3];
  endsequence
  property p_sleep_iso;
    @(posedge clk) disable iff (chan_rst)
      s_asleep3 |-> !d_oe && rx_line && !evt.thr_wr && !evt.rhr_rd;
  endproperty
  a_sleep_iso: assert property (p_sleep_iso) else $error("bus or receive input active in sleep");
endmodule
`default_nettype wire

/* bench/dur_host.sv */
/*
 Host processor model on the channel's 8-bit strobe bus.
 Assumes a read is answered within 8 clocks of the strobe falling.
*/
`timescale 1ns/1ps
`default_nettype none
module dur_host (
  input  wire logic       clk,   // System clock
  input  wire logic [7:0] rd_d,  // Device read data
  input  wire logic       rd_oe, // Device drives the bus
  output var logic        cs_n,  // Chip select
  output var logic        ior_n, // Read strobe
  output var logic        iow_n, // Write strobe
  output var logic [2:0]  addr,  // Register address
  output var logic [7:0]  wd     // Write data
);
  initial begin
    cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 3'h0;
    wd = 8'h00;
  end

  // Strobes held low 4 clocks and high 4 clocks, above the 3-clock minimum
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    iow_n <= 1'b0;
    addr <= a;
    wd <= v;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (4) @(posedge clk);
    wd <= ~v; // Released bus carries no stale data
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v, output logic hit);
    hit = 1'b0;
    v = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    ior_n <= 1'b0;
    addr <= a;
    for (int n = 0; n < 8 && !hit; n++) begin
      @(posedge clk);
      if (rd_oe === 1'b1) begin
        hit = 1'b1;
        v = rd_d;
      end
    end
    cs_n <= 1'b1;
    ior_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* bench/dual_uart_reset_state_bench.sv */
/*
 Self-checking bench of the channel register bank: reset values, the
 divisor's reset split, flow characters, modem status, sleep, bit rate.
 Assumes the host model drives the bus; datapath state is tied off.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_uart_reset_state_bench;
  logic               clk;
  logic               resetn;
  logic               ce;
  logic               rst_pin;
  logic               cs_n;
  logic               ior_n;
  logic               iow_n;
  logic [2:0]         addr;
  logic [7:0]         d_in;
  logic [7:0]         d_out;
  logic               d_oe;
  logic               rx_pin;
  logic [3:0]         modem_n;
  logic               sleep_en;
  dur_pkg::dur_stat_t stat;
  dur_pkg::dur_cfg_t  cfg;
  logic               chan_rst;
  logic               os_tick;
  int                 n_os;
  logic [15:0]        divisor;
  logic               rx_line;
  logic [7:0]         modem_status;
  logic               bit_tick;
  int                 n_mismatch;
  int                 cmp_count;
  int                 seed;
  int                 m_flow[4];
  int                 m_div;
  int                 gap;
  logic [7:0]         v;
  logic               h;

  dur_regs i_dur_regs (
    .clk(clk), .resetn(resetn), .ce(ce), .rst_pin(rst_pin),
    .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
    .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .rx_pin(rx_pin),
    .modem_n(modem_n), .sleep_en(sleep_en), .stat(stat), .cfg(cfg),
    .divisor(divisor), .evt(), .chan_rst(chan_rst), .rx_line(rx_line),
    .modem_status(modem_status), .os_tick(os_tick), .bit_tick(bit_tick)
  );

  dur_host i_dur_host (
    .clk(clk), .rd_d(d_out), .rd_oe(d_oe), .cs_n(cs_n),
    .ior_n(ior_n), .iow_n(iow_n), .addr(addr), .wd(d_in)
  );

  always #20 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] rv;
    logic       rh;
    i_dur_host.rd(a, rv, rh);
    chk({7'h00, rh, rv}, {8'h01, exp});
  endtask

  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cycles and oversample ticks between the 2nd and 3rd bit tick, 0 when fewer than 3 came in 300 cycles
  task automatic tick_gap;
    int k;
    int seen;
    int os_k;
    k = 0;
    seen = 0;
    os_k = 0;
    gap = 0;
    n_os = 0;
    for (int n = 0; n < 300 && seen < 3; n++) begin
      @(posedge clk);
      k++;
      if (os_tick === 1'b1) os_k++;
      if (bit_tick === 1'b1) begin
        seen++;
        if (seen == 3) begin
          gap = k;
          n_os = os_k;
        end
        k = 0;
        os_k = 0;
      end
    end
    if (gap == 0) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  initial begin
    clk = 1'b0;
    seed = 32'h6e1c;
    n_mismatch = 0;
    cmp_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    rst_pin = 1'b0;
    rx_pin = 1'b1;
    modem_n = 4'($random(seed));
    sleep_en = 1'b0;
    stat = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rchk(3'h1, 8'h00);
    rchk(3'h3, 8'h00);
    rchk(3'h4, 8'h00);
    rchk(3'h7, 8'hff);
    rchk(3'h6, {~modem_n, 4'h0});
    i_dur_host.wr(3'h7, 8'($random(seed)));
    i_dur_host.wr(3'h3, 8'h80);
    rchk(3'h0, 8'h01);
    rchk(3'h1, 8'h00);
    m_div = $random(seed) & 16'hffff;
    i_dur_host.wr(3'h0, 8'(m_div));
    i_dur_host.wr(3'h1, 8'(m_div >> 8));
    i_dur_host.wr(3'h3, dur_pkg::LCR_ENH_KEY);
    rchk(3'h2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m_flow[i] = $random(seed) & 8'hff;
      i_dur_host.wr(3'(4 + i), 8'(m_flow[i]));
    end
    for (int i = 0; i < 4; i++) rchk(3'(4 + i), 8'(m_flow[i]));
    chk({cfg.resume_char_one, cfg.pause_char_two}, {8'(m_flow[0]), 8'(m_flow[3])});
    modem_n[0] <= ~modem_n[0];
    repeat (5) @(posedge clk);
    chk({8'h00, modem_status}, {8'h00, ~modem_n, 4'h1});
    rst_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0000, chan_rst}, 16'h0001);
    rst_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk({8'h00, modem_status}, {8'h00, ~modem_n, 4'h0});
    chk(divisor, 16'(m_div));
    rchk(3'h3, 8'h00);
    rchk(3'h7, 8'hff);
    i_dur_host.wr(3'h3, dur_pkg::LCR_ENH_KEY);
    for (int i = 0; i < 4; i++) rchk(3'(4 + i), 8'h00);
    i_dur_host.wr(3'h3, 8'h80);
    rchk(3'h0, 8'(m_div));
    rchk(3'h1, 8'(m_div >> 8));
    m_div = 2;
    i_dur_host.wr(3'h0, 8'h02);
    i_dur_host.wr(3'h1, 8'h00);
    tick_gap();
    chk(16'(gap), 16'(dur_pkg::BAUD_OVERSAMPLE * m_div));
    chk(16'(n_os), 16'(dur_pkg::BAUD_OVERSAMPLE));
    i_dur_host.wr(3'h3, 8'h00);
    sleep_en <= 1'b1;
    rx_pin <= 1'b0;
    modem_n[3] <= ~modem_n[3];
    repeat (5) @(posedge clk);
    chk({15'h0000, rx_line}, 16'h0001);
    chk({8'h00, modem_status[7:4], 4'h0}, {8'h00, ~modem_n, 4'h0});
    i_dur_host.rd(3'h7, v, h);
    chk({15'h0000, h}, 16'h0000);
    i_dur_host.wr(3'h7, 8'h5a);
    sleep_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk({15'h0000, rx_line}, 16'h0000);
    rchk(3'h7, 8'hff);
    ce <= 1'b0;
    modem_n[1] <= ~modem_n[1];
    repeat (5) @(posedge clk);
    chk({8'h00, modem_status}, {8'h00, ~modem_n ^ 4'h2, 4'h8});
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk({8'h00, modem_status}, {8'h00, ~modem_n, 4'ha});
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    chk(divisor, dur_pkg::RST_DIV);
    i_dur_host.wr(3'h3, 8'h80);
    rchk(3'h0, 8'h01);
    rchk(3'h1, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
